// ### common/io_chain_pkg.sv
// package for the i/o flag priority chain: register map, field positions, reset values
// assumes a 32-bit apb slave at 20 mhz, one clock, no interrupt logic of its own
package io_chain_pkg;
    // ==========================================
    // slot code space
    localparam int NUM_CODES = 64;
    localparam logic [5:0] CODE_IRQ_ENABLE = 6'h00;
    localparam logic [5:0] CODE_POWER_FAIL = 6'h04;
    localparam logic [5:0] CODE_PARITY = 6'h05;
    localparam logic [5:0] CODE_DMA1 = 6'h06;
    localparam logic [5:0] CODE_DMA2 = 6'h07;
    localparam logic [5:0] CODE_FIRST_GP = 6'h08;
    // ==========================================
    // register byte offsets
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_ACC_A = 8'h04;
    localparam logic [7:0] OFS_ACC_B = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_FLAGS_LO = 8'h10;
    localparam logic [7:0] OFS_FLAGS_HI = 8'h14;
    localparam logic [7:0] OFS_CTRL_LO = 8'h18;
    localparam logic [7:0] OFS_CTRL_HI = 8'h1C;
    localparam logic [7:0] OFS_CONFIG = 8'h20;
    localparam logic [7:0] OFS_IRQ_MASK_LO = 8'h24;
    localparam logic [7:0] OFS_IRQ_MASK_HI = 8'h28;
    localparam logic [7:0] OFS_JUMPER_LO = 8'h2C;
    localparam logic [7:0] OFS_JUMPER_HI = 8'h30;
    localparam logic [7:0] OFS_BUF_DATA = 8'h34;
    // ==========================================
    // command register fields: [5:0] code, [10:8] op
    localparam int CMD_CODE_LSB = 0;
    localparam int CMD_OP_LSB = 8;
    // status fields
    localparam int ST_CODE_LSB = 0;
    localparam int ST_GRANT_BIT = 8;
    localparam int ST_IEN_BIT = 9;
    localparam int ST_HALT_BIT = 10;
    localparam int ST_PWR_BIT = 11;
    // config fields
    localparam int CFG_PARITY_HALT_BIT = 0;
    localparam logic [31:0] CFG_RESET = 32'h00000000;
    localparam logic [63:0] JUMPER_RESET = 64'h0000000000000000;
    localparam logic [63:0] MASK_RESET = 64'hFFFFFFFFFFFFFFFF;
    typedef enum logic [2:0] {
        OP_NONE,
        OP_SET_CONTROL,
        OP_CLEAR_CONTROL,
        OP_SET_FLAG,
        OP_CLEAR_FLAG,
        OP_OUT_A,
        OP_OUT_B,
        OP_ACK
    } io_op_t;
    typedef struct packed {
        logic valid;
        io_op_t op;
        logic [5:0] code;
    } io_cmd_t;
endpackage : io_chain_pkg

// ### dv/io_flag_priority_chain_chk.sv
// checker for the i/o flag priority chain, top-level ports only
// assumes one clock domain and the asynchronous active-low reset of the top
`timescale 1ns/1ns
module io_flag_priority_chain_chk #(
    parameter int NUM_CODES = 64,
    parameter int DATA_W = 16
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic i_dma1_req,
    input wire logic i_dma2_req,
    input wire logic i_preset,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic [NUM_CODES-1:0] o_dev_start,
    input wire logic [NUM_CODES-1:0] o_dev_control,
    input wire logic o_irq_grant,
    input wire logic [14:0] o_vector_addr,
    input wire logic o_halt,
    input wire logic o_dma1_grant,
    input wire logic o_dma2_grant
);
    // ==========================================
    // properties
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    a_ready_after_setup: assert property (i_psel && !i_penable |=> o_pready)
        else $error("ready missing after setup");
    a_error_reads_zero: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0)
        else $error("error response without ready or with data");
    a_start_from_cmd: assert property (|o_dev_start |-> $past(i_psel & i_penable & i_pwrite & ~|i_paddr))
        else $error("start without a command write");
    a_start_one_cycle: assert property (|o_dev_start |=> (o_dev_start & $past(o_dev_start)) == '0)
        else $error("start held longer than one cycle");
    a_vector_page_zero: assert property (o_irq_grant |-> o_vector_addr inside {[15'h0004:15'h003F]})
        else $error("vector outside page zero");
    a_dma_blocks_irq: assert property (
        $past(i_dma1_req || i_dma2_req) && o_irq_grant |-> o_vector_addr[5:0] == 6'h04)
        else $error("grant during dma transfer");
    a_dma_one_wins: assert property ((i_dma1_req && i_dma2_req) [*2] |-> o_dma1_grant && !o_dma2_grant)
        else $error("second dma channel won");
    a_grant_single: assert property (o_irq_grant |=> !o_irq_grant || $changed(o_vector_addr))
        else $error("grant repeated for one code");
    a_halt_sticky: assert property (o_halt && !i_preset |=> o_halt)
        else $error("halt dropped without preset");
    a_preset_clears: assert property (i_preset |-> ##2 o_dev_control == '0)
        else $error("control bits survive preset");
    c_grant: cover property (o_irq_grant);
    c_dma_both: cover property (i_dma1_req && i_dma2_req);
    c_halt: cover property ($rose(o_halt));
    c_refused: cover property (o_pslverr);
endmodule : io_flag_priority_chain_chk

bind io_flag_priority_chain io_flag_priority_chain_chk #(.NUM_CODES(NUM_CODES), .DATA_W(DATA_W)) chk (
    .i_clk, .i_resetn, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_dma1_req, .i_dma2_req, .i_preset,
    .o_prdata, .o_pready, .o_pslverr, .o_dev_start, .o_dev_control, .o_irq_grant, .o_vector_addr,
    .o_halt, .o_dma1_grant, .o_dma2_grant);

// ### dv/io_flag_priority_chain_tb_top.sv
// self-checking bench for the i/o flag priority chain
// assumes the slot device model beside it and the package in common/
`timescale 1ns/1ns
module io_flag_priority_chain_tb_top;
    logic i_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic [7:0] i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0;
    logic dma1 = 1'b0;
    logic dma2 = 1'b0;
    logic pfail = 1'b0;
    logic perr = 1'b0;
    logic preset = 1'b0;
    logic [63:0] dev_flag, dev_start, dev_ctl;
    logic [15:0] dev_data, out_data, in_word, out_word, wa;
    logic [31:0] prdata, rdat;
    logic [14:0] vec;
    logic [5:0] out_code, c;
    logic pready, pslverr, grant, halt, g1, g2;
    logic [5:0] gq[$];
    int num_errors = 0;
    int num_checks = 0;
    always #25 i_clk = ~i_clk;
    io_flag_priority_chain DUT (.i_clk(i_clk), .i_resetn(i_resetn), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_dev_flag(dev_flag), .i_dev_data(dev_data), .i_dma1_req(dma1),
        .i_dma2_req(dma2), .i_power_fail(pfail), .i_parity_error(perr), .i_preset(preset),
        .o_dev_start(dev_start), .o_dev_control(dev_ctl), .o_dev_data(out_data), .o_dev_data_code(out_code),
        .o_irq_grant(grant), .o_vector_addr(vec), .o_halt(halt), .o_dma1_grant(g1), .o_dma2_grant(g2));
    io_slot_dev_model dev (.i_clk(i_clk), .i_start(dev_start), .i_out_word(out_data), .o_flag(dev_flag),
        .o_data(dev_data), .o_in_word(in_word), .o_out_word(out_word));
    always @(posedge i_clk) if (grant === 1'b1) gq.push_back(vec[5:0]);
    // ==========================================
    // helpers
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_of_test
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t ns: got %h want %h", $time, got, exp);
        end
    endtask : chk_word
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdat = prdata;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        chk_word({31'h0, pready}, 32'h1);
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk_word(rdat, exp);
    endtask : rd
    // set-control always clears the flag in the same write
    task automatic cmd(input io_chain_pkg::io_op_t op, input logic [5:0] k);
        apb(1'b1, io_chain_pkg::OFS_CMD, {20'h0, op == io_chain_pkg::OP_SET_CONTROL, op, 2'b00, k});
    endtask : cmd
    task automatic grant_is(input logic [5:0] k);
        int n;
        n = 0;
        while (gq.size() == 0 && n < 40) begin
            @(posedge i_clk);
            n++;
        end
        chk_word({26'h0, gq.size() > 0 ? gq.pop_front() : 6'bx}, {26'h0, k});
    endtask : grant_is
    task automatic no_grant(input int n);
        repeat (n) @(posedge i_clk);
        chk_word(32'(gq.size()), 32'h0);
        gq.delete();
    endtask : no_grant
    initial begin
        #(20000 * 50);
        num_errors++;
        $display("unexpected at %0t ns: run hung", $time);
        end_of_test();
    end
    // ==========================================
    // tests
    initial begin
        void'($urandom(95611));
        repeat (8) @(posedge i_clk);
        i_resetn <= 1'b1;
        rd(io_chain_pkg::OFS_FLAGS_HI, 32'hFFFFFFFF);
        rd(io_chain_pkg::OFS_CTRL_LO, 32'h0);
        rd(io_chain_pkg::OFS_IRQ_MASK_LO, 32'hFFFFFFFF);
        rd(io_chain_pkg::OFS_STATUS, 32'h00000100);
        chk_word({31'h0, rdat[io_chain_pkg::ST_IEN_BIT]}, 32'h0);
        apb(1'b0, 8'h3C, 32'h0);
        chk_word({pslverr, rdat[30:0]}, 32'h80000000);
        for (int k = 0; k < 64; k++) cmd(io_chain_pkg::OP_CLEAR_FLAG, 6'(k));
        gq.delete();
        $display("test reset done");
        cmd(io_chain_pkg::OP_SET_CONTROL, 6'h0A);
        repeat (12) @(posedge i_clk);
        wa = in_word;
        cmd(io_chain_pkg::OP_SET_CONTROL, 6'h0C);
        repeat (12) @(posedge i_clk);
        rd(io_chain_pkg::OFS_FLAGS_LO, 32'h00001400);
        apb(1'b1, io_chain_pkg::OFS_JUMPER_LO, 32'h00000300);
        no_grant(2);
        cmd(io_chain_pkg::OP_SET_FLAG, 6'h00);
        grant_is(6'h0A);
        rd(io_chain_pkg::OFS_BUF_DATA, {16'h0, wa});
        no_grant(10);
        cmd(io_chain_pkg::OP_CLEAR_FLAG, 6'h0A);
        no_grant(10);
        apb(1'b1, io_chain_pkg::OFS_JUMPER_LO, 32'h00000B00);
        grant_is(6'h0C);
        cmd(io_chain_pkg::OP_SET_FLAG, 6'h0A);
        grant_is(6'h0A);
        cmd(io_chain_pkg::OP_CLEAR_FLAG, 6'h0C);
        cmd(io_chain_pkg::OP_CLEAR_FLAG, 6'h0A);
        apb(1'b1, io_chain_pkg::OFS_IRQ_MASK_LO, 32'hFFFFFBFF);
        cmd(io_chain_pkg::OP_SET_FLAG, 6'h0A);
        no_grant(10);
        apb(1'b1, io_chain_pkg::OFS_IRQ_MASK_LO, 32'hFFFFFFFF);
        grant_is(6'h0A);
        cmd(io_chain_pkg::OP_CLEAR_FLAG, 6'h0A);
        $display("test chain done");
        wa = 16'($urandom);
        apb(1'b1, io_chain_pkg::OFS_ACC_A, {16'h0, wa});
        cmd(io_chain_pkg::OP_OUT_A, 6'h0D);
        @(negedge i_clk);
        chk_word({10'h0, out_code, out_data}, {10'h0, 6'h0D, wa});
        apb(1'b1, io_chain_pkg::OFS_ACC_B, {16'h0, ~wa});
        cmd(io_chain_pkg::OP_OUT_B, 6'h0D);
        @(negedge i_clk);
        chk_word({16'h0, out_data}, {16'h0, ~wa});
        cmd(io_chain_pkg::OP_SET_CONTROL, 6'h0D);
        grant_is(6'h0D);
        chk_word({16'h0, out_word}, {16'h0, ~wa});
        cmd(io_chain_pkg::OP_CLEAR_FLAG, 6'h0D);
        $display("test output done");
        apb(1'b1, io_chain_pkg::OFS_JUMPER_LO, 32'hFFFFFFFF);
        apb(1'b1, io_chain_pkg::OFS_JUMPER_HI, 32'hFFFFFFFF);
        for (int i = 0; i < 8; i++) begin
            c = 6'(8 + $urandom % 56);
            cmd(io_chain_pkg::OP_SET_CONTROL, c);
            grant_is(c);
            rd(io_chain_pkg::OFS_BUF_DATA, {16'h0, in_word});
            cmd(io_chain_pkg::OP_CLEAR_FLAG, c);
            cmd(io_chain_pkg::OP_CLEAR_CONTROL, c);
        end
        $display("test random done");
        dma1 <= 1'b1;
        cmd(io_chain_pkg::OP_SET_CONTROL, 6'h0A);
        no_grant(12);
        pfail <= 1'b1;
        grant_is(6'h04);
        dma2 <= 1'b1;
        repeat (2) @(negedge i_clk);
        chk_word({30'h0, g1, g2}, 32'h2);
        @(posedge i_clk);
        dma1 <= 1'b0;
        dma2 <= 1'b0;
        cmd(io_chain_pkg::OP_CLEAR_FLAG, 6'h04);
        grant_is(6'h0A);
        cmd(io_chain_pkg::OP_CLEAR_FLAG, 6'h0A);
        pfail <= 1'b0;
        grant_is(6'h04);
        cmd(io_chain_pkg::OP_CLEAR_FLAG, 6'h04);
        perr <= 1'b1;
        grant_is(6'h05);
        perr <= 1'b0;
        cmd(io_chain_pkg::OP_CLEAR_FLAG, 6'h05);
        apb(1'b1, io_chain_pkg::OFS_CONFIG, 32'h00000001);
        perr <= 1'b1;
        no_grant(4);
        chk_word({31'h0, halt}, 32'h1);
        perr <= 1'b0;
        preset <= 1'b1;
        @(posedge i_clk);
        preset <= 1'b0;
        rd(io_chain_pkg::OFS_FLAGS_LO, 32'hFFFFFFFE);
        chk_word({31'h0, halt}, 32'h0);
        $display("test dma power parity done");
        end_of_test();
    end
endmodule : io_flag_priority_chain_tb_top

// ### dv/io_slot_dev_model.sv
// peripheral devices behind the slot cards
// assumes start pulses one cycle wide and one transfer in flight at a time
`timescale 1ns/1ns
module io_slot_dev_model #(
    parameter int N = 64,
    parameter int W = 16
) (
    input wire logic i_clk,
    input wire logic [N-1:0] i_start,
    input wire logic [W-1:0] i_out_word,
    output logic [N-1:0] o_flag = '0,
    output logic [W-1:0] o_data = '0,
    output logic [W-1:0] o_in_word = '0,
    output logic [W-1:0] o_out_word = '0
);
    // ==========================================
    // each start is answered after a random delay
    always begin : dev
        int k;
        logic [W-1:0] w;
        @(posedge i_clk);
        if (|i_start) begin
            k = 0;
            while (!i_start[k]) k++;
            o_out_word <= i_out_word;
            repeat (1 + $urandom % 6) @(posedge i_clk);
            w = W'($urandom);
            o_in_word <= w;
            o_data <= w;
            o_flag[k] <= 1'b1;
            repeat (2) @(posedge i_clk);
            o_flag[k] <= 1'b0;
        end else begin
            o_data <= ~o_data; // idle bus toggles so a stale word is never mistaken for data
        end
    end
endmodule : io_slot_dev_model

// ### hdl/io_flag_priority_chain.sv
// top of the i/o flag priority chain: per-slot control/flag bits, buffers, priority grant
// assumes apb master, slot devices on plain per-code strobes, cpu takes o_vector_* on grant
// Summary of operation
// - set-control issues start, optional flag clear
// - asserted flag becomes interrupt request
// - output copies accumulator into slot buffer
// - power fail highest, codes descend after
// - dma blocks all but power fail
// - dma channel one beats channel two
// - set flag blocks lower chain positions
// - higher request may nest over lower
// - code and priority come from slot
// - each slot offers two select codes
// - chain continuous, empty slots need jumper
// - parity error halts or interrupts code five
// - power loss vectors to power routine
// - grant puts code in address register
// - preset clears controls, sets all flags except code zero
// - flag of code zero gates interrupts
// - no grant while globally or locally disabled; power fail ignores mask and control, parity ignores control
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ns
module io_flag_priority_chain #(
    parameter int NUM_CODES = io_chain_pkg::NUM_CODES,
    parameter int DATA_W = 16
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [NUM_CODES-1:0] i_dev_flag,
    input wire logic [DATA_W-1:0] i_dev_data,
    input wire logic i_dma1_req,
    input wire logic i_dma2_req,
    input wire logic i_power_fail,
    input wire logic i_parity_error,
    input wire logic i_preset,
    output logic [NUM_CODES-1:0] o_dev_start,
    output logic [NUM_CODES-1:0] o_dev_control,
    output logic [DATA_W-1:0] o_dev_data,
    output logic [5:0] o_dev_data_code,
    output logic o_irq_grant,
    output logic [14:0] o_vector_addr,
    output logic o_halt,
    output logic o_dma1_grant,
    output logic o_dma2_grant
);
    // ==========================================
    // apb decode
    logic access;
    logic wr_en;
    logic known;
    io_chain_pkg::io_cmd_t cmd;
    assign access = i_psel & i_penable;
    assign wr_en = access & i_pwrite;
    always_comb begin
        case (i_paddr)
            io_chain_pkg::OFS_CMD, io_chain_pkg::OFS_ACC_A, io_chain_pkg::OFS_ACC_B,
            io_chain_pkg::OFS_STATUS, io_chain_pkg::OFS_FLAGS_LO, io_chain_pkg::OFS_FLAGS_HI,
            io_chain_pkg::OFS_CTRL_LO, io_chain_pkg::OFS_CTRL_HI, io_chain_pkg::OFS_CONFIG,
            io_chain_pkg::OFS_IRQ_MASK_LO, io_chain_pkg::OFS_IRQ_MASK_HI,
            io_chain_pkg::OFS_JUMPER_LO, io_chain_pkg::OFS_JUMPER_HI,
            io_chain_pkg::OFS_BUF_DATA: known = 1'b1;
            default: known = 1'b0;
        endcase
    end
    always_comb begin
        cmd.valid = wr_en & (i_paddr == io_chain_pkg::OFS_CMD);
        cmd.op = io_chain_pkg::io_op_t'(i_pwdata[io_chain_pkg::CMD_OP_LSB +: 3]);
        cmd.code = i_pwdata[io_chain_pkg::CMD_CODE_LSB +: 6];
    end
    // a clear-flag bit rides with set-control so both land in one command
    logic cmd_clf_too;
    assign cmd_clf_too = i_pwdata[11];

    function automatic logic [NUM_CODES-1:0] code_hot(input logic [5:0] c);
        code_hot = '0;
        code_hot[c] = 1'b1;
    endfunction : code_hot

    logic [NUM_CODES-1:0] sel;
    logic do_stc;
    logic do_clc;
    logic do_stf;
    logic do_clf;
    logic do_out;
    assign sel = code_hot(cmd.code);
    assign do_stc = cmd.valid & (cmd.op == io_chain_pkg::OP_SET_CONTROL);
    assign do_clc = cmd.valid & (cmd.op == io_chain_pkg::OP_CLEAR_CONTROL);
    assign do_stf = cmd.valid & (cmd.op == io_chain_pkg::OP_SET_FLAG);
    assign do_clf = cmd.valid & ((cmd.op == io_chain_pkg::OP_CLEAR_FLAG) | (do_stc & cmd_clf_too));
    assign do_out = cmd.valid & ((cmd.op == io_chain_pkg::OP_OUT_A) | (cmd.op == io_chain_pkg::OP_OUT_B));

    // ==========================================
    // software registers
    logic [DATA_W-1:0] acc_a_q;
    logic [DATA_W-1:0] acc_b_q;
    logic [31:0] config_q;
    logic [63:0] mask_q;
    logic [63:0] jumper_q;
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            acc_a_q <= '0;
            acc_b_q <= '0;
            config_q <= io_chain_pkg::CFG_RESET;
            mask_q <= io_chain_pkg::MASK_RESET;
            jumper_q <= io_chain_pkg::JUMPER_RESET;
        end else if (wr_en) begin
            case (i_paddr)
                io_chain_pkg::OFS_ACC_A: acc_a_q <= i_pwdata[DATA_W-1:0];
                io_chain_pkg::OFS_ACC_B: acc_b_q <= i_pwdata[DATA_W-1:0];
                io_chain_pkg::OFS_CONFIG: config_q <= i_pwdata;
                io_chain_pkg::OFS_IRQ_MASK_LO: mask_q[31:0] <= i_pwdata;
                io_chain_pkg::OFS_IRQ_MASK_HI: mask_q[63:32] <= i_pwdata;
                io_chain_pkg::OFS_JUMPER_LO: jumper_q[31:0] <= i_pwdata;
                io_chain_pkg::OFS_JUMPER_HI: jumper_q[63:32] <= i_pwdata;
                default: ;
            endcase
        end
    end

    // ==========================================
    // control and flag bits, one pair per select code
    logic [NUM_CODES-1:0] control_q;
    logic [NUM_CODES-1:0] flag_q;
    logic [NUM_CODES-1:0] dev_flag_q;
    logic [NUM_CODES-1:0] flag_rise;
    logic [NUM_CODES-1:0] hw_set;
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            dev_flag_q <= '0;
        end else begin
            dev_flag_q <= i_dev_flag;
        end
    end
    assign flag_rise = i_dev_flag & ~dev_flag_q;
    logic pwr_q;
    logic pwr_rise;
    logic parity_irq;
    always_comb begin
        hw_set = flag_rise;
        hw_set[io_chain_pkg::CODE_POWER_FAIL] = pwr_rise;
        hw_set[io_chain_pkg::CODE_PARITY] = parity_irq;
    end
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pwr_q <= 1'b0;
        end else begin
            pwr_q <= i_power_fail;
        end
    end
    assign pwr_rise = (i_power_fail ^ pwr_q); // loss and return both vector
    assign parity_irq = i_parity_error & ~config_q[io_chain_pkg::CFG_PARITY_HALT_BIT];

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            control_q <= '0;
            flag_q <= ~code_hot(io_chain_pkg::CODE_IRQ_ENABLE);
        end else if (i_preset) begin
            control_q <= '0;
            flag_q <= ~code_hot(io_chain_pkg::CODE_IRQ_ENABLE);
        end else begin
            for (int k = 0; k < NUM_CODES; k++) begin
                if (do_stc && sel[k]) begin
                    control_q[k] <= 1'b1;
                end else if (do_clc && sel[k]) begin
                    control_q[k] <= 1'b0;
                end
                // hardware set wins over a same-cycle clear; flag holds otherwise
                if (hw_set[k] || (do_stf && sel[k])) begin
                    flag_q[k] <= 1'b1;
                end else if (do_clf && sel[k]) begin
                    flag_q[k] <= 1'b0;
                end
            end
        end
    end

    // ==========================================
    // slot buffers; one buffer per select code, not shared between the two codes of a slot
    logic [DATA_W-1:0] buf_q [NUM_CODES];
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int k = 0; k < NUM_CODES; k++) begin
                buf_q[k] <= '0;
            end
        end else begin
            for (int k = 0; k < NUM_CODES; k++) begin
                if (do_out && sel[k]) begin
                    buf_q[k] <= (cmd.op == io_chain_pkg::OP_OUT_A) ? acc_a_q : acc_b_q;
                end else if (flag_rise[k]) begin
                    buf_q[k] <= i_dev_data;
                end
            end
        end
    end

    // ==========================================
    // device-facing outputs
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_dev_start <= '0;
            o_dev_control <= '0;
            o_dev_data <= '0;
            o_dev_data_code <= 6'h00;
        end else begin
            o_dev_start <= do_stc ? sel : '0;
            o_dev_control <= control_q;
            if (do_out) begin
                o_dev_data <= (cmd.op == io_chain_pkg::OP_OUT_A) ? acc_a_q : acc_b_q;
                o_dev_data_code <= cmd.code;
            end
        end
    end

    // ==========================================
    // request vector and chain
    logic [NUM_CODES-1:0] req;
    logic [NUM_CODES-1:0] present;
    logic hit;
    logic [5:0] win_code;
    logic ien;
    logic dma_busy;
    assign ien = flag_q[io_chain_pkg::CODE_IRQ_ENABLE];
    assign dma_busy = i_dma1_req | i_dma2_req;
    always_comb begin
        for (int k = 0; k < NUM_CODES; k++) begin
            // codes below four never interrupt; slot pair {2n,2n+1} ranks by code
            req[k] = flag_q[k] & control_q[k] & mask_q[k] & (k >= 4);
            // fixed positions always present, general slots by card or jumper
            present[k] = (k < 8) | i_dev_flag[k] | control_q[k] | jumper_q[k]
                | flag_q[k];
        end
        req[io_chain_pkg::CODE_POWER_FAIL] = flag_q[io_chain_pkg::CODE_POWER_FAIL];
        req[io_chain_pkg::CODE_PARITY] = flag_q[io_chain_pkg::CODE_PARITY] & mask_q[5];
    end
    prio_chain #(
        .N(NUM_CODES)
    ) u_chain (
        .i_req(req),
        .i_present(present),
        .o_hit(hit),
        .o_code(win_code)
    );

    // ==========================================
    // grant; nesting is free since a higher flag always outranks the one in service
    logic grant_ok;
    assign grant_ok = hit & ien
        & (~dma_busy | (win_code == io_chain_pkg::CODE_POWER_FAIL));
    logic [5:0] last_code_q;
    logic held_q;
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_irq_grant <= 1'b0;
            o_vector_addr <= '0;
            last_code_q <= 6'h00;
            held_q <= 1'b0;
        end else begin
            // one-cycle grant, re-offered while the winner stays the same is suppressed
            o_irq_grant <= grant_ok & ~(held_q & (last_code_q == win_code));
            held_q <= grant_ok;
            if (grant_ok) begin
                o_vector_addr <= {9'h000, win_code};
                last_code_q <= win_code;
            end
        end
    end
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_dma1_grant <= 1'b0;
            o_dma2_grant <= 1'b0;
            o_halt <= 1'b0;
        end else begin
            o_dma1_grant <= i_dma1_req;
            o_dma2_grant <= i_dma2_req & ~i_dma1_req;
            if (i_parity_error && config_q[io_chain_pkg::CFG_PARITY_HALT_BIT]) begin
                o_halt <= 1'b1;
            end else if (i_preset) begin
                o_halt <= 1'b0;
            end
        end
    end

    // ==========================================
    // apb read and response
    logic [31:0] rd;
    always_comb begin
        rd = '0;
        case (i_paddr)
            io_chain_pkg::OFS_ACC_A: rd[DATA_W-1:0] = acc_a_q;
            io_chain_pkg::OFS_ACC_B: rd[DATA_W-1:0] = acc_b_q;
            io_chain_pkg::OFS_STATUS: begin
                rd[io_chain_pkg::ST_CODE_LSB +: 6] = last_code_q;
                rd[io_chain_pkg::ST_GRANT_BIT] = hit;
                rd[io_chain_pkg::ST_IEN_BIT] = ien;
                rd[io_chain_pkg::ST_HALT_BIT] = o_halt;
                rd[io_chain_pkg::ST_PWR_BIT] = i_power_fail;
            end
            io_chain_pkg::OFS_FLAGS_LO: rd = flag_q[31:0];
            io_chain_pkg::OFS_FLAGS_HI: rd = flag_q[63:32];
            io_chain_pkg::OFS_CTRL_LO: rd = control_q[31:0];
            io_chain_pkg::OFS_CTRL_HI: rd = control_q[63:32];
            io_chain_pkg::OFS_CONFIG: rd = config_q;
            io_chain_pkg::OFS_IRQ_MASK_LO: rd = mask_q[31:0];
            io_chain_pkg::OFS_IRQ_MASK_HI: rd = mask_q[63:32];
            io_chain_pkg::OFS_JUMPER_LO: rd = jumper_q[31:0];
            io_chain_pkg::OFS_JUMPER_HI: rd = jumper_q[63:32];
            io_chain_pkg::OFS_BUF_DATA: rd[DATA_W-1:0] = buf_q[last_code_q];
            default: rd = '0;
        endcase
    end
    // registered response: no wait state, so pready and data both leave flops
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_pready <= 1'b0;
            o_prdata <= '0;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= i_psel & ~i_penable;
            o_pslverr <= i_psel & ~i_penable & ~known;
            o_prdata <= (i_psel & ~i_penable & ~i_pwrite) ? rd : 32'h00000000;
        end
    end
endmodule : io_flag_priority_chain

// ### hdl/prio_chain.sv
// priority chain: lowest set request index wins, gated by continuity
// assumes request vector already qualified by flag and mask
`timescale 1ns/1ns
module prio_chain #(
    parameter int N = 64
) (
    input wire logic [N-1:0] i_req,
    input wire logic [N-1:0] i_present,
    output logic o_hit,
    output logic [5:0] o_code
);
    logic [N:0] pass;
    logic [N-1:0] win;
    assign pass[0] = 1'b1;
    // ==========================================
    // daisy chain: a set request blocks everything below it
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_link
            assign win[g] = pass[g] & i_req[g] & i_present[g];
            // empty slot without jumper breaks the string
            assign pass[g+1] = pass[g] & i_present[g] & ~i_req[g];
        end
    endgenerate
    always_comb begin
        o_hit = 1'b0;
        o_code = 6'h00;
        for (int k = N - 1; k >= 0; k--) begin
            if (win[k]) begin
                o_hit = 1'b1;
                o_code = 6'(k);
            end
        end
    end
endmodule : prio_chain
